// file: adc_output_ctl_dev.sv
// Converter end: sample buffer, output ports, sync and serial settings.
`timescale 1ns/100ps
// Functional notes
// - Accept one new sample every clock edge.
// - Output words are 12 bits, bit 0 least.
// - Port update rate is clock over ratio.
// - Strobe toggles at half clock over ratio.
// - Receiver captures on both strobe edges.
// - One parity bit beside each port word.
// - Sync acts on one programmable edge.
// - Edge select 1 falling, 0 rising.
// - Behaviour select 1 trigger, 0 reset.
// - Serial port enabled when enable pin low.
// - Serial data shifted on serial clock rising.
// - Shift only while load enable held low.
// - Configuration reset restores all serial defaults.
// - Serial port on ignores the four mode pins; sync and config reset still act.
// - Serial port off holds defaults, uses pins.
// - Ratio select 1 two ports, 0 one.
// - Coarse delay codes map 0 to 90 ps.
// - Gain, offset, fine delay take 10 bits.
// - Pattern kind picks static or dynamic patterns.
// - Test pattern enable, active low, pin or serial.
// - Delay tune: pin fine only, serial both.
// - Decimate-by-8 mode from pin or serial.
module adc_output_ctl_dev #(
	parameter int BUF_DEPTH = 2,
	parameter int WIDTH = adc_ctl_pkg::SAMPLE_BITS
) (
	input wire logic clk,
	input wire logic rst_n,
	adc_link_if.dev link,
	input wire logic [WIDTH-1:0] sampleData,
	input wire logic sampleValid,
	output logic sampleReady,
	output logic [adc_ctl_pkg::TRIM_BITS-1:0] gainTrim,
	output logic [adc_ctl_pkg::TRIM_BITS-1:0] offsetTrim,
	output logic [adc_ctl_pkg::TRIM_BITS-1:0] delayFine,
	output logic [1:0] delayCoarse,
	output logic delayTuneOn,
	output logic trimFromPins,
	output logic syncResetPulse,
	output logic triggerPulse
);
	import adc_ctl_pkg::*;
	localparam int NPIN = 9;
	localparam int PW = $clog2(BUF_DEPTH);
	localparam int CW = $clog2(BUF_DEPTH + 1);
	// Idle level of each pin, in the order of pinRaw below.
	localparam logic [NPIN-1:0] PIN_IDLE = {RST_DECIM_LOW, RST_DELAY_EN_LOW,
		RST_TEST_EN_LOW, RST_RATIO, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

	// Pin inputs pass three stages; a change counts once two agree.
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] s1;
	logic [NPIN-1:0] s2;
	logic [NPIN-1:0] s3;
	logic [NPIN-1:0] pin;
	assign pinRaw = {link.decimateBy8Low, link.delayTuneEnLow,
		link.testPatternEnLow, link.demuxRatioSel, link.serialEnLow,
		link.syncIn, link.sldLow, link.sdata, link.sclk};
	// Stages reset to the idle level, so release shows no false edge.
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1[gi] <= PIN_IDLE[gi];
					s2[gi] <= PIN_IDLE[gi];
					s3[gi] <= PIN_IDLE[gi];
					pin[gi] <= PIN_IDLE[gi];
				end else begin
					s1[gi] <= pinRaw[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi]) pin[gi] <= s3[gi];
				end
			end
		end
	endgenerate
	wire sclkIn = pin[0];
	wire sdataIn = pin[1];
	wire sldIn = pin[2];
	wire syncPin = pin[3];
	wire serialOn = !pin[4];
	logic sclkPrev;
	logic sldPrev;
	logic syncPrev;

	// Serial shift register; the config reset pin also clears settings.
	wire settingsRst_n = rst_n & link.cfgRstLow;
	logic [WORD_BITS-1:0] shiftReg;
	logic [4:0] bitCount;
	logic [5:0] stateReg;
	logic [9:0] regGain;
	logic [9:0] regOffset;
	logic [9:0] regFine;
	logic [1:0] regCoarse;
	logic [1:0] regKind;
	wire shiftEdge = sclkIn && !sclkPrev && !sldIn && serialOn;
	wire wordDone = sldIn && !sldPrev && bitCount == 5'(WORD_BITS);
	wire [3:0] wAddr = shiftReg[WORD_BITS-1 -: ADDR_BITS];
	wire [11:0] wData = shiftReg[SAMPLE_BITS-1:0];
	always_ff @(posedge clk or negedge settingsRst_n) begin
		if (!settingsRst_n) begin
			shiftReg <= '0;
			bitCount <= '0;
		end else if (shiftEdge) begin
			shiftReg <= {shiftReg[WORD_BITS-2:0], sdataIn};
			if (bitCount != 5'h1f) bitCount <= bitCount + 5'h1;
		end else if (sldIn) begin
			bitCount <= '0;
		end
	end

	// Settings commit on load enable release; serial off forces defaults.
	always_ff @(posedge clk or negedge settingsRst_n) begin
		if (!settingsRst_n) begin
			stateReg <= {RST_BEHAV, RST_EDGE, RST_DECIM_LOW,
				RST_TEST_EN_LOW, RST_DELAY_EN_LOW, RST_RATIO};
			regGain <= RST_GAIN;
			regOffset <= RST_OFFSET;
			regFine <= RST_FINE;
			regCoarse <= RST_COARSE;
			regKind <= KIND_ALIGN;
		end else if (!serialOn) begin
			stateReg <= {RST_BEHAV, RST_EDGE, RST_DECIM_LOW,
				RST_TEST_EN_LOW, RST_DELAY_EN_LOW, RST_RATIO};
			regGain <= RST_GAIN;
			regOffset <= RST_OFFSET;
			regFine <= RST_FINE;
			regCoarse <= RST_COARSE;
			regKind <= KIND_ALIGN;
		end else if (wordDone) begin
			if (wAddr == ADDR_STATE) stateReg <= wData[5:0];
			if (wAddr == ADDR_GAIN) regGain <= wData[FINE_MSB:0];
			if (wAddr == ADDR_OFFSET) regOffset <= wData[FINE_MSB:0];
			if (wAddr == ADDR_DELAY) begin
				regFine <= wData[FINE_MSB:0];
				regCoarse <= wData[COARSE_MSB:COARSE_LSB];
			end
			if (wAddr == ADDR_TEST) regKind <= wData[1:0];
		end
	end

	// Effective settings: serial values win while the port is on.
	wire twoPort = serialOn ? stateReg[BIT_RATIO] : pin[5];
	wire testOn = !(serialOn ? stateReg[BIT_TEST_EN] : pin[6]);
	wire decimOn = !(serialOn ? stateReg[BIT_DECIM] : pin[8]);
	wire tuneOn = !(serialOn ? stateReg[BIT_DELAY_EN] : pin[7]);
	// Static patterns only reachable serially.
	wire [1:0] kind = serialOn ? regKind : KIND_ALIGN;
	wire edgeFall = stateReg[BIT_EDGE];
	wire syncEdge = edgeFall ? (syncPrev && !syncPin)
		: (!syncPrev && syncPin);
	wire syncReset = syncEdge && !stateReg[BIT_BEHAV];

	// Two-entry buffer; the source stalls on sampleReady when full.
	logic [WIDTH-1:0] bufMem [BUF_DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [CW-1:0] count;
	wire push = sampleValid && sampleReady;
	wire pop = count != '0;
	wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
	wire [WIDTH-1:0] word = bufMem[rdPtr];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			sampleReady <= 1'b1;
		end else begin
			if (push) wrPtr <= PW'((wrPtr + 1'b1) % BUF_DEPTH);
			if (pop) rdPtr <= PW'((rdPtr + 1'b1) % BUF_DEPTH);
			count <= next_count;
			sampleReady <= next_count < CW'(BUF_DEPTH);
		end
	end
	always_ff @(posedge clk) begin
		if (push) bufMem[wrPtr] <= sampleData;
	end

	// Output assembly: decimation, pairing and test patterns.
	logic [2:0] decCnt;
	logic half;
	logic [3:0] patCnt;
	logic [WIDTH-1:0] holdA;
	wire keep = pop && (!decimOn || decCnt == '0);
	wire pairDone = !twoPort || half;
	logic patBit;
	always_comb begin
		unique case (patCnt[3:2])
			2'h0: patBit = 1'b0;
			2'h1: patBit = patCnt[1];
			2'h2: patBit = patCnt[0];
			default: patBit = ~patCnt[0];
		endcase
	end
	wire patOut = kind == KIND_ONE ? 1'b1
		: kind == KIND_ZERO ? 1'b0 : patBit;
	wire [WIDTH-1:0] patWord = {WIDTH{patOut}};
	wire [WIDTH-1:0] outA = testOn ? patWord : (twoPort ? holdA : word);
	wire [WIDTH-1:0] outB = testOn ? patWord : word;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decCnt <= '0;
			half <= 1'b0;
			patCnt <= '0;
			holdA <= '0;
			link.portA <= '0;
			link.portB <= '0;
			link.parityBitPortA <= 1'b0;
			link.parityBitPortB <= 1'b0;
			link.sampleStrobeOut <= 1'b0;
		end else if (syncReset) begin
			decCnt <= '0;
			half <= 1'b0;
			patCnt <= '0;
			link.sampleStrobeOut <= 1'b0;
		end else begin
			if (pop) decCnt <= decCnt + 3'h1;
			if (keep && !pairDone) begin
				holdA <= word;
				half <= 1'b1;
			end else if (keep) begin
				half <= 1'b0;
				patCnt <= patCnt + 4'h1;
				link.portA <= outA;
				// Parity is the xor of the word; pattern copies its bit.
				link.parityBitPortA <= testOn ? patOut : ^outA;
				if (twoPort) begin
					link.portB <= outB;
					link.parityBitPortB <= testOn ? patOut : ^outB;
				end
				link.sampleStrobeOut <= !link.sampleStrobeOut;
			end
		end
	end

	// Edge history, trim outputs and sync pulses.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev <= 1'b0;
			sldPrev <= 1'b1;
			syncPrev <= 1'b0;
			gainTrim <= RST_GAIN;
			offsetTrim <= RST_OFFSET;
			delayFine <= RST_FINE;
			delayCoarse <= RST_COARSE;
			delayTuneOn <= 1'b0;
			trimFromPins <= 1'b1;
			syncResetPulse <= 1'b0;
			triggerPulse <= 1'b0;
		end else begin
			sclkPrev <= sclkIn;
			sldPrev <= sldIn;
			syncPrev <= syncPin;
			gainTrim <= regGain;
			offsetTrim <= regOffset;
			delayFine <= regFine;
			delayCoarse <= regCoarse;
			delayTuneOn <= tuneOn;
			trimFromPins <= !serialOn;
			syncResetPulse <= syncReset;
			triggerPulse <= syncEdge && stateReg[BIT_BEHAV];
		end
	end
endmodule : adc_output_ctl_dev

// file: adc_ctl_pkg.sv
// Shared constants for the converter output and serial control ends.
package adc_ctl_pkg;
	localparam int SAMPLE_BITS = 12;
	localparam int TRIM_BITS = 10;
	localparam int ADDR_BITS = 4;
	localparam int WORD_BITS = ADDR_BITS + SAMPLE_BITS;
	localparam int SYNC_STAGES = 3;
	localparam int SCLK_HALF = 4;
	localparam int PATTERN_LEN = 16;
	localparam int DECIM_FACTOR = 8;
	// Serial register addresses.
	localparam logic [3:0] ADDR_STATE = 4'h0;
	localparam logic [3:0] ADDR_GAIN = 4'h1;
	localparam logic [3:0] ADDR_OFFSET = 4'h2;
	localparam logic [3:0] ADDR_DELAY = 4'h3;
	localparam logic [3:0] ADDR_TEST = 4'h5;
	// State register bit positions.
	localparam int BIT_RATIO = 0;
	localparam int BIT_DELAY_EN = 1;
	localparam int BIT_TEST_EN = 2;
	localparam int BIT_DECIM = 3;
	localparam int BIT_EDGE = 4;
	localparam int BIT_BEHAV = 5;
	// Delay register fields.
	localparam int COARSE_LSB = 10;
	localparam int COARSE_MSB = 11;
	localparam int FINE_MSB = 9;
	// Defaults after reset or with the serial port off.
	localparam logic RST_RATIO = 1'b1;
	localparam logic RST_DELAY_EN_LOW = 1'b1;
	localparam logic RST_TEST_EN_LOW = 1'b1;
	localparam logic RST_DECIM_LOW = 1'b1;
	localparam logic RST_EDGE = 1'b0;
	localparam logic RST_BEHAV = 1'b0;
	localparam logic [9:0] RST_GAIN = 10'h200;
	localparam logic [9:0] RST_OFFSET = 10'h200;
	localparam logic [9:0] RST_FINE = 10'h000;
	localparam logic [1:0] RST_COARSE = 2'h2;
	// Output pattern kinds.
	localparam logic [1:0] KIND_ZERO = 2'h0;
	localparam logic [1:0] KIND_ONE = 2'h1;
	localparam logic [1:0] KIND_ALIGN = 2'h3;
endpackage : adc_ctl_pkg

// file: adc_link_if.sv
// Pins between the converter end and its receiver and serial master.
`timescale 1ns/100ps
interface adc_link_if;
	logic [11:0] portA;
	logic [11:0] portB;
	logic parityBitPortA;
	logic parityBitPortB;
	logic sampleStrobeOut;
	logic syncIn;
	logic sclk;
	logic sdata;
	logic sldLow;
	logic cfgRstLow;
	logic serialEnLow;
	logic demuxRatioSel;
	logic testPatternEnLow;
	logic delayTuneEnLow;
	logic decimateBy8Low;
	modport dev (
		output portA, portB, parityBitPortA, parityBitPortB,
		output sampleStrobeOut,
		input syncIn, sclk, sdata, sldLow, cfgRstLow, serialEnLow,
		input demuxRatioSel, testPatternEnLow, delayTuneEnLow,
		input decimateBy8Low
	);
	modport host (
		input portA, portB, parityBitPortA, parityBitPortB,
		input sampleStrobeOut,
		output syncIn, sclk, sdata, sldLow, cfgRstLow, serialEnLow,
		output demuxRatioSel, testPatternEnLow, delayTuneEnLow,
		output decimateBy8Low
	);
endinterface : adc_link_if

// file: adc_output_ctl_host.sv
// Receiver and serial master end: captures ports, writes settings.
`timescale 1ns/100ps
module adc_output_ctl_host (
	input wire logic clk,
	input wire logic rst_n,
	adc_link_if.host link,
	input wire logic [adc_ctl_pkg::ADDR_BITS-1:0] cfgAddr,
	input wire logic [adc_ctl_pkg::SAMPLE_BITS-1:0] cfgData,
	input wire logic cfgStart,
	output logic cfgBusy,
	input wire logic cfgResetLow,
	input wire logic serialEnLow,
	input wire logic demuxRatioSel,
	input wire logic testPatternEnLow,
	input wire logic delayTuneEnLow,
	input wire logic decimateBy8Low,
	input wire logic syncLevel,
	output logic [adc_ctl_pkg::SAMPLE_BITS-1:0] rxPortA,
	output logic [adc_ctl_pkg::SAMPLE_BITS-1:0] rxPortB,
	output logic rxValid,
	output logic rxParityErr
);
	import adc_ctl_pkg::*;
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		SHIFT = 3'b010,
		GAP = 3'b100
	} master_t;
	master_t state;
	logic [WORD_BITS-1:0] txWord;
	logic [3:0] bitIdx;
	logic [2:0] divCnt;
	logic strobePrev;
	wire tick = divCnt == 3'(SCLK_HALF - 1);
	// Words are taken on either strobe edge.
	wire strobeEdge = link.sampleStrobeOut != strobePrev;
	wire badA = (^link.portA) != link.parityBitPortA;
	wire badB = (^link.portB) != link.parityBitPortB;

	// Capture both ports; parity is unchecked while the test pattern pin is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobePrev <= 1'b0;
			rxPortA <= '0;
			rxPortB <= '0;
			rxValid <= 1'b0;
			rxParityErr <= 1'b0;
		end else begin
			strobePrev <= link.sampleStrobeOut;
			rxValid <= strobeEdge;
			if (strobeEdge) begin
				rxPortA <= link.portA;
				rxPortB <= link.portB;
				rxParityErr <= testPatternEnLow
					&& (badA || (demuxRatioSel && badB));
			end
		end
	end

	// Hardware pins are registered straight from the user inputs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.cfgRstLow <= 1'b0;
			link.serialEnLow <= 1'b1;
			link.demuxRatioSel <= RST_RATIO;
			link.testPatternEnLow <= 1'b1;
			link.delayTuneEnLow <= 1'b1;
			link.decimateBy8Low <= 1'b1;
			link.syncIn <= 1'b0;
		end else begin
			link.cfgRstLow <= cfgResetLow;
			link.serialEnLow <= serialEnLow;
			link.demuxRatioSel <= demuxRatioSel;
			link.testPatternEnLow <= testPatternEnLow;
			link.delayTuneEnLow <= delayTuneEnLow;
			link.decimateBy8Low <= decimateBy8Low;
			link.syncIn <= syncLevel;
		end
	end

	// Serial master: data changes after falling edges, most bit first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IDLE;
			txWord <= '0;
			bitIdx <= '0;
			divCnt <= '0;
			cfgBusy <= 1'b0;
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.sldLow <= 1'b1;
		end else begin
			divCnt <= (state == IDLE || tick) ? 3'h0 : divCnt + 3'h1;
			unique case (state)
				IDLE: begin
					if (cfgStart) begin
						txWord <= {cfgAddr, cfgData};
						bitIdx <= 4'(WORD_BITS - 1);
						link.sdata <= cfgAddr[ADDR_BITS-1];
						link.sldLow <= 1'b0;
						cfgBusy <= 1'b1;
						state <= SHIFT;
					end
				end
				SHIFT: begin
					if (tick && !link.sclk) begin
						link.sclk <= 1'b1;
					end else if (tick) begin
						link.sclk <= 1'b0;
						if (bitIdx == '0) begin
							state <= GAP;
						end else begin
							bitIdx <= bitIdx - 4'h1;
							link.sdata <= txWord[bitIdx - 4'h1];
						end
					end
				end
				default: begin
					if (tick) begin
						link.sldLow <= 1'b1;
						cfgBusy <= 1'b0;
						state <= IDLE;
					end
				end
			endcase
		end
	end
endmodule : adc_output_ctl_host

// file: adc_output_and_serial_control_monitor.sv
// Checker for the pins between the converter end and its receiver.
`timescale 1ns/100ps
module adc_output_and_serial_control_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] portA,
	input wire logic [11:0] portB,
	input wire logic parityBitPortA,
	input wire logic parityBitPortB,
	input wire logic sampleStrobeOut,
	input wire logic syncIn,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic sldLow,
	input wire logic serialEnLow,
	input wire logic demuxRatioSel,
	input wire logic testPatternEnLow,
	input wire logic decimateBy8Low
);
	logic [3:0] quiet;
	logic [4:0] bitCount;
	wire pinOk;
	wire [4:0] pinBus;
	// Pin checks wait until the pins have passed the synchronisers.
	assign pinBus = {serialEnLow, demuxRatioSel, testPatternEnLow,
		decimateBy8Low, syncIn};
	assign pinOk = serialEnLow && testPatternEnLow && decimateBy8Low
		&& quiet >= 4'ha;
	// Cycles since the serial, ratio, test, decimate or sync pin last moved, saturating.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 4'h0;
		end else if ($changed(pinBus)) begin
			quiet <= 4'h0;
		end else if (quiet != 4'hf) begin
			quiet <= quiet + 4'h1;
		end
	end
	// Serial clock rises seen inside the current load window.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCount <= 5'h0;
		end else if (sldLow) begin
			bitCount <= 5'h0;
		end else if ($rose(sclk)) begin
			bitCount <= bitCount + 5'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_parity_port_a: assert property (pinOk |-> parityBitPortA == ^portA)
		else $error("Port A parity bit does not match its word.");
	a_parity_port_b: assert property (pinOk && demuxRatioSel |->
		parityBitPortB == ^portB)
		else $error("Port B parity bit does not match its word.");
	a_pair_spacing: assert property (pinOk && demuxRatioSel &&
		$changed(sampleStrobeOut) |=> $stable(sampleStrobeOut))
		else $error("Strobe toggled twice in a row in two-port mode.");
	a_port_b_idle: assert property (pinOk && !demuxRatioSel |->
		$stable(portB))
		else $error("Port B moved in one-port mode.");
	a_port_with_strobe: assert property (pinOk &&
		$stable(sampleStrobeOut) |-> $stable(portA))
		else $error("Port A changed without a strobe toggle.");
	a_sclk_high_len: assert property ($rose(sclk) |->
		sclk [*4] ##1 !sclk)
		else $error("Serial clock high phase has the wrong length.");
	a_sdata_hold: assert property (sclk |-> $stable(sdata))
		else $error("Serial data moved while the serial clock was high.");
	a_sclk_idle: assert property (sldLow |-> !sclk)
		else $error("Serial clock high outside a load window.");
	a_word_length: assert property ($rose(sldLow) |->
		bitCount == 5'h10)
		else $error("Load window did not hold sixteen bits.");
endmodule : adc_output_and_serial_control_monitor

// file: adc_output_and_serial_control_test.sv
// Testbench joining the converter end and the receiver end.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin \
	errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module adc_output_and_serial_control_test;
	import adc_ctl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] cfgAddr = 4'h0;
	logic [11:0] cfgData = 12'h000, sampleData = 12'h000;
	logic cfgStart = 1'b0, cfgResetLow = 1'b1, serialEnLow = 1'b1;
	logic demuxRatioSel = 1'b0, testPatternEnLow = 1'b1;
	logic delayTuneEnLow = 1'b1, decimateBy8Low = 1'b1, syncLevel = 1'b0;
	logic sampleValid = 1'b0;
	logic cfgBusy, rxValid, rxParityErr, sampleReady, delayTuneOn;
	logic trimFromPins, syncResetPulse, triggerPulse;
	logic [11:0] rxPortA, rxPortB;
	logic [9:0] gainTrim, offsetTrim, delayFine;
	logic [1:0] delayCoarse;
	logic [11:0] qa[$], qb[$];
	// Bit i is the alignment level at step i after a sync restart.
	localparam logic [15:0] ALIGN_SEQ = 16'h5ac0;
	int errors = 0, totalChecks = 0, cycles = 0;
	int trigCount = 0, syncCount = 0, t0, s0;
	adc_link_if link();
	adc_output_ctl_dev i_adc_output_ctl_dev (.clk(clk), .rst_n(rst_n),
		.link(link), .sampleData(sampleData), .sampleValid(sampleValid),
		.sampleReady(sampleReady), .gainTrim(gainTrim),
		.offsetTrim(offsetTrim), .delayFine(delayFine),
		.delayCoarse(delayCoarse), .delayTuneOn(delayTuneOn),
		.trimFromPins(trimFromPins), .syncResetPulse(syncResetPulse),
		.triggerPulse(triggerPulse));
	adc_output_ctl_host i_adc_output_ctl_host (.clk(clk), .rst_n(rst_n),
		.link(link), .cfgAddr(cfgAddr), .cfgData(cfgData),
		.cfgStart(cfgStart), .cfgBusy(cfgBusy), .cfgResetLow(cfgResetLow),
		.serialEnLow(serialEnLow), .demuxRatioSel(demuxRatioSel),
		.testPatternEnLow(testPatternEnLow),
		.delayTuneEnLow(delayTuneEnLow), .decimateBy8Low(decimateBy8Low),
		.syncLevel(syncLevel), .rxPortA(rxPortA), .rxPortB(rxPortB),
		.rxValid(rxValid), .rxParityErr(rxParityErr));
	adc_output_and_serial_control_monitor
		i_adc_output_and_serial_control_monitor (
		.clk(clk), .rst_n(rst_n), .portA(link.portA), .portB(link.portB),
		.parityBitPortA(link.parityBitPortA),
		.parityBitPortB(link.parityBitPortB),
		.sampleStrobeOut(link.sampleStrobeOut), .syncIn(link.syncIn),
		.sclk(link.sclk), .sdata(link.sdata), .sldLow(link.sldLow),
		.serialEnLow(link.serialEnLow), .demuxRatioSel(link.demuxRatioSel),
		.testPatternEnLow(link.testPatternEnLow),
		.decimateBy8Low(link.decimateBy8Low));
	always #4 clk = ~clk;
	// Capture received words and pulses; a hang is cut at the ceiling.
	always @(posedge clk) begin
		cycles++;
		if (rxValid === 1'b1) begin
			qa.push_back(rxPortA);
			qb.push_back(rxPortB);
		end
		if (triggerPulse === 1'b1) trigCount++;
		if (syncResetPulse === 1'b1) syncCount++;
		if (cycles == 30000) begin
			errors++;
			endOfTest();
		end
	end
	// Pins cross three synchronisers, so give them a generous margin.
	task automatic settle();
		repeat (12) @(posedge clk);
	endtask : settle
	// One serial word: start pulse, then wait for the busy flag to drop.
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		int n;
		@(posedge clk);
		cfgAddr <= a;
		cfgData <= d;
		cfgStart <= 1'b1;
		@(posedge clk);
		cfgStart <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cfgBusy !== 1'b0 && n < 300);
		`CHK("busy", 1'b0, cfgBusy)
		settle();
	endtask : wr
	// Back-to-back source words; data only advances when accepted.
	task automatic send(input int n, input logic [11:0] base);
		int i;
		i = 0;
		qa.delete();
		qb.delete();
		@(posedge clk);
		sampleValid <= 1'b1;
		sampleData <= base;
		while (i < n) begin
			@(posedge clk);
			if (sampleReady === 1'b1) begin
				i++;
				sampleData <= base + 12'(i);
			end
		end
		sampleValid <= 1'b0;
		settle();
	endtask : send
	task automatic endOfTest();
		$display("Checks %0d, mismatches %0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : endOfTest
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		`CHK("gain", RST_GAIN, gainTrim)
		`CHK("coarse", RST_COARSE, delayCoarse)
		`CHK("pins", 1'b1, trimFromPins)
		`CHK("ready", 1'b1, sampleReady)
		$display("Test reset done");
		send(5, 12'h7a5);
		`CHK("count1", 5, qa.size())
		foreach (qa[i]) `CHK("portA", 12'h7a5 + 12'(i), qa[i])
		`CHK("parity", 1'b0, rxParityErr)
		demuxRatioSel <= 1'b1;
		settle();
		send(6, 12'h100);
		`CHK("count2", 3, qa.size())
		foreach (qa[i]) `CHK("pairA", 12'h100 + 12'(2 * i), qa[i])
		foreach (qb[i]) `CHK("pairB", 12'h101 + 12'(2 * i), qb[i])
		$display("Test ports done");
		serialEnLow <= 1'b0;
		settle();
		wr(ADDR_GAIN, 12'h3ff);
		wr(ADDR_OFFSET, 12'h001);
		wr(ADDR_DELAY, {2'h3, 10'h155});
		wr(ADDR_STATE, 12'h00d);
		`CHK("gainW", 10'h3ff, gainTrim)
		`CHK("offW", 10'h001, offsetTrim)
		`CHK("fineW", 10'h155, delayFine)
		`CHK("coarseW", 2'h3, delayCoarse)
		`CHK("tuneOn", 1'b1, delayTuneOn)
		`CHK("serial", 1'b0, trimFromPins)
		cfgResetLow <= 1'b0;
		repeat (4) @(posedge clk);
		cfgResetLow <= 1'b1;
		settle();
		`CHK("gainR", RST_GAIN, gainTrim)
		`CHK("tuneR", 1'b0, delayTuneOn)
		wr(ADDR_GAIN, 12'h055);
		`CHK("gain5", 10'h055, gainTrim)
		serialEnLow <= 1'b1;
		settle();
		wr(ADDR_GAIN, 12'h0aa);
		`CHK("gainOff", RST_GAIN, gainTrim)
		$display("Test settings done");
		serialEnLow <= 1'b0;
		settle();
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_STATE, 12'h00f | (12'(k) << 4));
			t0 = trigCount;
			s0 = syncCount;
			syncLevel <= 1'b1;
			settle();
			`CHK("rise", k % 2 == 0, trigCount + syncCount - t0 - s0)
			syncLevel <= 1'b0;
			settle();
			`CHK("trig", k / 2, trigCount - t0)
			`CHK("sync", 1 - k / 2, syncCount - s0)
		end
		$display("Test sync done");
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_TEST, k == 0 ? {10'h0, KIND_ZERO} : {10'h0, KIND_ONE});
			wr(ADDR_STATE, 12'h00a);
			send(4, 12'h3c3);
			`CHK("countT", 4, qa.size())
			foreach (qa[i]) `CHK("pattern", k == 0 ? 12'h000 : 12'hfff, qa[i])
		end
		wr(ADDR_STATE, 12'h006);
		send(16, 12'h200);
		`CHK("decim", 2, qa.size())
		`CHK("decim0", 12'h200, qa[0])
		`CHK("decim1", 12'h208, qa[1])
		// Pins own the modes again; a sync restarts the alignment pattern.
		serialEnLow <= 1'b1;
		demuxRatioSel <= 1'b0;
		testPatternEnLow <= 1'b0;
		delayTuneEnLow <= 1'b0;
		settle();
		`CHK("tunePin", 1'b1, delayTuneOn)
		syncLevel <= 1'b1;
		settle();
		syncLevel <= 1'b0;
		send(16, 12'h0f0);
		`CHK("countA", 16, qa.size())
		foreach (qa[i]) `CHK("align", {12{ALIGN_SEQ[i]}}, qa[i])
		$display("Test modes done");
		endOfTest();
	end
endmodule : adc_output_and_serial_control_test
